// ===== hdl/edc_pkg.sv
// Event dispatch controller: shared constants, register map and timing.
// Assumes one 20 MHz clock and a plain word-aligned register port.
package edc_pkg;

  // Source indices, highest priority first
  localparam int         NSRC      = 114;
  localparam int         VEC_W     = 7;
  localparam int         NKEY      = 10;
  localparam int         HOST_MAX  = 99;
  localparam logic [6:0] IDX_PORT1 = 7'h00;
  localparam logic [6:0] IDX_PORT2 = 7'h01;
  localparam logic [6:0] IDX_KEY0  = 7'h02;
  localparam logic [6:0] IDX_HOST0 = 7'h0B;  // Host event n sits at IDX_HOST0 + n
  localparam logic [6:0] IDX_ALARM = 7'h6F;
  localparam logic [6:0] IDX_TIMER = 7'h70;
  localparam logic [6:0] IDX_TOD   = 7'h71;

  // Gate states of one source
  localparam logic [1:0] GATE_OFF  = 2'h0;
  localparam logic [1:0] GATE_ON   = 2'h1;
  localparam logic [1:0] GATE_HOLD = 2'h2;
  localparam logic [1:0] GATE_RST  = GATE_OFF;

  // Receive trigger modes
  typedef enum logic [1:0] {RX_CHAR, RX_COUNT, RX_FRAME, RX_HEADCNT} edc_rx_mode_t;

  // Register byte offsets
  localparam logic [7:0] REG_GATE   = 8'h00;
  localparam logic [7:0] REG_PORT1  = 8'h04;
  localparam logic [7:0] REG_PORT2  = 8'h08;
  localparam logic [7:0] REG_TIMER  = 8'h0C;
  localparam logic [7:0] REG_ALARM  = 8'h10;
  localparam logic [7:0] REG_TOD    = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Field positions
  localparam int GATE_IDX_LSB = 0;
  localparam int GATE_ST_LSB  = 8;
  localparam int GATE_PND_BIT = 10;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CODE_LSB = 8;
  localparam int CFG_HEAD_LSB = 16;
  localparam int CFG_CNT_LSB  = 24;
  localparam int TOD_SEC_LSB  = 0;
  localparam int TOD_MIN_LSB  = 8;
  localparam int TOD_HR_LSB   = 16;
  localparam int TOD_WLD_LSB  = 24;
  localparam int TMR_ARM_BIT  = 31;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_FPND_BIT  = 1;
  localparam int ST_REFU_BIT  = 2;
  localparam int ST_VEC_LSB   = 8;

  // Reset values of configuration words
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] TOD_RST = 32'h0700_0000;

  // Timing: one interval unit is 100 ms
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          TICK_MS       = 100;
  localparam int          TICK_CYC      = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int          TICK_W        = 24;
  localparam int          IVL_W         = 20;
  localparam logic [19:0] IVL_MAX       = 20'hD_2F00;

endpackage : edc_pkg

// ===== hdl/edc_rx_trigger.sv
// Receive trigger of one serial port: watches bytes entering its buffer.
// Assumes rx_valid is a one-cycle strobe on the same clock as the block.
module edc_rx_trigger
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Configuration
  input  wire edc_pkg::edc_rx_mode_t mode,
  input  wire logic [7:0]           code,
  input  wire logic [7:0]           head,
  input  wire logic [7:0]           count,
  // Received byte stream
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_byte,
  // Trigger pulse
  output logic                      fire
);
  import edc_pkg::*;

  logic       frame_q;  // Start character seen
  logic [7:0] cnt_q;    // Bytes counted so far
  logic [7:0] cnt_inc;  // Count after this byte
  logic       fire_q;   // Registered trigger

  assign cnt_inc = cnt_q + 8'h01;
  assign fire    = fire_q;

  // Byte matching; the buffer keeps storing bytes in every mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_q <= 1'b0;
      cnt_q   <= 8'h00;
      fire_q  <= 1'b0;
    end
    else
    begin
      fire_q <= 1'b0;
      if (rx_valid)
      begin
        unique case (mode)
          RX_CHAR:    fire_q <= (rx_byte == code);  // R2
          RX_COUNT:                                  // R3
          begin
            // A count of zero acts as one, so the trigger never stalls
            if (cnt_inc >= count)
            begin
              fire_q <= 1'b1;
              cnt_q  <= 8'h00;
            end
            else
              cnt_q <= cnt_inc;
          end
          RX_FRAME:                                  // R4
          begin
            if (!frame_q)
              frame_q <= (rx_byte == head);
            else if (rx_byte == code)
            begin
              fire_q  <= 1'b1;
              frame_q <= 1'b0;
            end
          end
          RX_HEADCNT:                                // R5
          begin
            if (!frame_q)
            begin
              frame_q <= (rx_byte == head);
              cnt_q   <= 8'h00;
            end
            else if (cnt_inc >= count)
            begin
              fire_q  <= 1'b1;
              frame_q <= 1'b0;
            end
            else
              cnt_q <= cnt_inc;
          end
        endcase
      end
    end
  end

endmodule : edc_rx_trigger

// ===== hdl/edc_ctrl.sv
// Event dispatch controller: gates, pending records and priority dispatch.
// Assumes a 20 MHz clock, a plain register port and asynchronous key/word pins.
// Contract
// R1: Each serial port has own gated receive source
// R2: Character-match mode fires on configured character
// R3: Byte-count mode fires at configured byte count
// R4: Framed mode fires on end after start
// R5: Start-plus-count fires count bytes after start
// R6: Ten key sources, each individually gated
// R7: Word bit04 raises host event from number
// R8: Host message write raises numbered host event
// R9: Message writes refused while busy flag set
// R10: Periodic timer repeats every interval of 0.1s
// R11: Interval 300 fires at thirty seconds, repeating
// R12: Alarm fires once after its interval
// R13: Scheduled source fires on time pattern match
// R14: Fault event raised on detected error
// R15: Gate states: enabled, disabled, held
// R16: Held events stay pending until enabled
// R17: Dispatch waits for current operation to finish
// R18: Simultaneous events dispatched one at a time
// R19: Fixed priority: ports, keys, host, alarm, timer, time
// R20: Events wait for handler; faults go immediately
// R21: At most one pending record per source
// R22: Dispatch clears record; disabling discards it
module edc_ctrl
#(
  parameter int TICK_CYCLES = edc_pkg::TICK_CYC  // Cycles per 0.1 s unit
)
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  // Serial receive streams
  input  wire logic                      rx_valid_p1,
  input  wire logic [7:0]                rx_byte_p1,
  input  wire logic                      rx_valid_p2,
  input  wire logic [7:0]                rx_byte_p2,
  // Key pins
  input  wire logic [edc_pkg::NKEY-1:0]  key_in,
  // Allocated host words (pins)
  input  wire logic                      allocated_io_word0_b4,
  input  wire logic [7:0]                allocated_io_word2_lo,
  // Host message write
  input  wire logic                      host_message_write,
  input  wire logic [7:0]                host_message_num,
  // Real-time clock
  input  wire logic [7:0]                rtc_hour,
  input  wire logic [7:0]                rtc_min,
  input  wire logic [7:0]                rtc_sec,
  // Interpreter side
  input  wire logic                      fault_event,
  input  wire logic                      op_busy,
  input  wire logic                      handler_done,
  output logic                           handler_branch,
  output logic      [edc_pkg::VEC_W-1:0] handler_vector,
  output logic                           fault_branch,
  output logic                           busy_flag
);
  import edc_pkg::*;

  localparam int PIN_W = NKEY + 9;  // Keys, word bit 04, number byte

  // First set bit, lowest index wins
  function automatic logic [VEC_W-1:0] first_set(input logic [NSRC-1:0] v);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        r = VEC_W'(i);
    return r;
  endfunction : first_set

  // Bits strictly below an index
  function automatic logic [NSRC-1:0] below(input logic [VEC_W-1:0] idx);
    logic [NSRC-1:0] m;
    m = '0;
    for (int i = 0; i < NSRC; i++)
      m[i] = (VEC_W'(i) < idx);
    return m;
  endfunction : below

  // Host number in the legal 1..99 range
  function automatic logic host_ok(input logic [7:0] n);
    return (n != 8'h00) && (n <= 8'(HOST_MAX));
  endfunction : host_ok

  logic [1:0]        gate_q [NSRC];  // Per-source gate state
  logic [VEC_W-1:0]  gsel_q;         // Last addressed gate
  logic [NSRC-1:0]   pend_q, pend_d; // Pending records
  logic [NSRC-1:0]   ev;             // Raw events this cycle
  logic [NSRC-1:0]   on_vec, off_vec;
  logic [NSRC-1:0]   elig;           // Pending and enabled
  logic [31:0]       cfg_q [2];      // Port trigger configs
  logic [1:0]        rx_fire;
  logic [PIN_W-1:0]  s1_q, s2_q, s3_q, filt_q;
  logic [PIN_W-1:0]  filt_d, rise;
  logic [IVL_W-1:0]  ivl_q [2];      // 0 periodic, 1 alarm
  logic [TICK_W-1:0] pre_q [2];      // Cycles within a unit
  logic [IVL_W-1:0]  tk_q [2];       // Units elapsed
  logic [1:0]        arm_q, tmr_fire;
  logic [31:0]       tod_q;          // Time pattern and wildcards
  logic              tod_hit, tod_hit_q;
  logic              hnd_q, br_q, fb_q, fpend_q, refuse_q;
  logic [VEC_W-1:0]  vec_q;
  logic              take, msg_ok;
  logic [VEC_W-1:0]  take_idx;
  logic [31:0]       rd_mux, rdata_q;

  assign reg_rdata      = rdata_q;
  assign handler_branch = br_q;
  assign handler_vector = vec_q;
  assign fault_branch   = fb_q;
  assign busy_flag      = hnd_q;

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end
    else
    begin
      s1_q   <= {allocated_io_word2_lo, allocated_io_word0_b4, key_in};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  assign rise   = filt_d & ~filt_q;

  // One receive trigger per port, each with its own config
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    edc_rx_trigger u_trig (                                         // R1
      .clk      (clk),
      .reset_n  (reset_n),
      .mode     (edc_rx_mode_t'(cfg_q[p][CFG_MODE_LSB +: 2])),
      .code     (cfg_q[p][CFG_CODE_LSB +: 8]),
      .head     (cfg_q[p][CFG_HEAD_LSB +: 8]),
      .count    (cfg_q[p][CFG_CNT_LSB +: 8]),
      .rx_valid (p == 0 ? rx_valid_p1 : rx_valid_p2),
      .rx_byte  (p == 0 ? rx_byte_p1 : rx_byte_p2),
      .fire     (rx_fire[p])
    );
  end

  // Interval timers; each has its own prescaler so arming is exact
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int t = 0; t < 2; t++)
      begin
        ivl_q[t] <= '0;
        pre_q[t] <= '0;
        tk_q[t]  <= '0;
        arm_q[t] <= 1'b0;
      end
    else
      for (int t = 0; t < 2; t++)
      begin
        if (reg_wr && reg_addr == (t == 0 ? REG_TIMER : REG_ALARM))
        begin
          // Out-of-range intervals clamp to the maximum
          ivl_q[t] <= (reg_wdata[IVL_W-1:0] > IVL_MAX) ? IVL_MAX : reg_wdata[IVL_W-1:0];
          arm_q[t] <= reg_wdata[TMR_ARM_BIT];
          pre_q[t] <= '0;
          tk_q[t]  <= '0;
        end
        else if (arm_q[t])
        begin
          if (pre_q[t] == TICK_W'(TICK_CYCLES - 1))
            pre_q[t] <= '0;
          else
            pre_q[t] <= pre_q[t] + 1'b1;
          if (tmr_fire[t])
          begin
            tk_q[t]  <= '0;                                         // R10 R11
            arm_q[t] <= (t == 0);                                   // R12
          end
          else if (pre_q[t] == TICK_W'(TICK_CYCLES - 1))
            tk_q[t] <= tk_q[t] + 1'b1;
        end
      end
  end

  // Expiry at the end of the unit that completes the interval
  always_comb
  begin
    for (int t = 0; t < 2; t++)
      tmr_fire[t] = arm_q[t] && (pre_q[t] == TICK_W'(TICK_CYCLES - 1))
                    && (tk_q[t] + 1'b1 >= ivl_q[t]);                // R10
  end

  // Time-of-day match; a wildcard bit ignores that field
  assign tod_hit = (tod_q[TOD_WLD_LSB + 2] || rtc_hour == tod_q[TOD_HR_LSB +: 8])
                && (tod_q[TOD_WLD_LSB + 1] || rtc_min == tod_q[TOD_MIN_LSB +: 8])
                && (tod_q[TOD_WLD_LSB] || rtc_sec == tod_q[TOD_SEC_LSB +: 8]);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tod_hit_q <= 1'b1;  // No spurious event straight out of reset
    else
      tod_hit_q <= tod_hit;
  end

  // Message writes are only taken while no handler runs
  assign msg_ok = host_message_write && !hnd_q && host_ok(host_message_num);  // R8 R9

  // Event vector in priority order
  always_comb
  begin
    ev = '0;
    ev[IDX_PORT1] = rx_fire[0];                                     // R1
    ev[IDX_PORT2] = rx_fire[1];
    for (int k = 0; k < NKEY; k++)
      ev[IDX_KEY0 + k] = rise[k];                                   // R6
    if (rise[NKEY] && host_ok(filt_d[NKEY+1 +: 8]))
      ev[IDX_HOST0 + 7'(filt_d[NKEY+1 +: 8])] = 1'b1;               // R7
    if (msg_ok)
      ev[IDX_HOST0 + 7'(host_message_num)] = 1'b1;                  // R8
    ev[IDX_ALARM] = tmr_fire[1];                                    // R12
    ev[IDX_TIMER] = tmr_fire[0];                                    // R10
    ev[IDX_TOD]   = tod_hit && !tod_hit_q;                          // R13
  end

  // Gate decode
  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      on_vec[i]  = (gate_q[i] == GATE_ON);                          // R15
      off_vec[i] = (gate_q[i] != GATE_ON) && (gate_q[i] != GATE_HOLD);
    end
  end

  assign elig     = pend_q & on_vec;                                // R16
  assign take     = (|elig) && !hnd_q && !op_busy;                  // R17 R20
  assign take_idx = first_set(elig);                                // R18 R19

  // Pending records: set wins over the dispatch clear
  always_comb
  begin
    pend_d = pend_q;
    if (take)
      pend_d[take_idx] = 1'b0;                                      // R22
    pend_d = (pend_d | ev) & ~off_vec;                              // R21 R22
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pend_q <= '0;
    else
      pend_q <= pend_d;
  end

  // Dispatch of ordinary handlers, one at a time
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      br_q  <= 1'b0;
      vec_q <= '0;
      hnd_q <= 1'b0;
    end
    else
    begin
      br_q <= take;
      if (take)
      begin
        vec_q <= take_idx;
        hnd_q <= 1'b1;                                              // R20
      end
      else if (handler_done)
        hnd_q <= 1'b0;
    end
  end

  // Fault dispatch ignores a running handler, not the current operation
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fpend_q <= 1'b0;
      fb_q    <= 1'b0;
    end
    else
    begin
      fb_q    <= fpend_q && !op_busy && !fb_q;                      // R14 R17 R20
      fpend_q <= fault_event || (fpend_q && !(fpend_q && !op_busy && !fb_q));
    end
  end

  // Configuration and gate writes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NSRC; i++)
        gate_q[i] <= GATE_RST;
      gsel_q   <= '0;
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
      tod_q    <= TOD_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        REG_GATE:
        begin
          // Indices past the last source are ignored
          if (reg_wdata[GATE_IDX_LSB +: VEC_W] < VEC_W'(NSRC))
          begin
            gate_q[reg_wdata[GATE_IDX_LSB +: VEC_W]] <= reg_wdata[GATE_ST_LSB +: 2]; // R15
            gsel_q <= reg_wdata[GATE_IDX_LSB +: VEC_W];
          end
        end
        REG_PORT1: cfg_q[0] <= reg_wdata;
        REG_PORT2: cfg_q[1] <= reg_wdata;
        REG_TOD:   tod_q    <= reg_wdata;
        default:   ;
      endcase
    end
  end

  // Sticky refusal flag; a new refusal wins over the write that clears it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      refuse_q <= 1'b0;
    else if (host_message_write && hnd_q)
      refuse_q <= 1'b1;                                             // R9
    else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_REFU_BIT])
      refuse_q <= 1'b0;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      REG_GATE:
      begin
        rd_mux[GATE_IDX_LSB +: VEC_W] = gsel_q;
        rd_mux[GATE_ST_LSB +: 2]      = gate_q[gsel_q];
        rd_mux[GATE_PND_BIT]          = pend_q[gsel_q];
      end
      REG_PORT1: rd_mux = cfg_q[0];
      REG_PORT2: rd_mux = cfg_q[1];
      REG_TIMER: rd_mux = {arm_q[0], 11'h000, ivl_q[0]};
      REG_ALARM: rd_mux = {arm_q[1], 11'h000, ivl_q[1]};
      REG_TOD:   rd_mux = tod_q;
      REG_STATUS:
      begin
        rd_mux[ST_BUSY_BIT]         = hnd_q;
        rd_mux[ST_FPND_BIT]         = fpend_q;
        rd_mux[ST_REFU_BIT]         = refuse_q;
        rd_mux[ST_VEC_LSB +: VEC_W] = vec_q;
      end
      default:   rd_mux = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= '0;
    else
      rdata_q <= reg_rd ? rd_mux : '0;
  end

  // Checks
  a_disp_when_idle: assert property (@(posedge clk) disable iff (!reset_n) // R17
    br_q |-> $past(!hnd_q && !op_busy))
    else $error("dispatch while busy");
  a_disp_only_on: assert property (@(posedge clk) disable iff (!reset_n) // R15
    br_q |-> $past(on_vec[take_idx] && pend_q[take_idx]))
    else $error("dispatch of a source not enabled");
  a_prio_order: assert property (@(posedge clk) disable iff (!reset_n) // R19
    br_q |-> (($past(elig) & below(vec_q)) == '0))
    else $error("higher priority source skipped");
  a_one_at_time: assert property (@(posedge clk) disable iff (!reset_n) // R18
    br_q |=> !br_q ##0 busy_flag)
    else $error("second dispatch without handler return");
  a_off_discards: assert property (@(posedge clk) disable iff (!reset_n) // R22
    (pend_q & $past(off_vec)) == '0)
    else $error("pending record kept on disabled source");
  a_fault_now: assert property (@(posedge clk) disable iff (!reset_n) // R20
    (fault_event && !op_busy && !fpend_q) ##1 !op_busy |=> fb_q)
    else $error("fault not dispatched during handler");
  a_msg_refused: assert property (@(posedge clk) disable iff (!reset_n) // R9
    (host_message_write && busy_flag) |=> refuse_q)
    else $error("busy message write not refused");
  a_alarm_once: assert property (@(posedge clk) disable iff (!reset_n) // R12
    (tmr_fire[1] && !(reg_wr && reg_addr == REG_ALARM)) |=> !arm_q[1])
    else $error("alarm still armed after firing");
  a_timer_repeat: assert property (@(posedge clk) disable iff (!reset_n) // R10
    (tmr_fire[0] && !(reg_wr && reg_addr == REG_TIMER)) |=> arm_q[0] && tk_q[0] == '0)
    else $error("periodic timer did not restart");

endmodule : edc_ctrl

// ===== tb/edc_host_model.sv
// Host CPU model: drives the allocated word pins and message writes.
// Assumes the controller samples these pins on rising clk edges.
module edc_host_model
(
  // Clock
  input  wire logic       clk,
  // Allocated word pins
  output logic            word0_b4,
  output logic [7:0]      word2_lo,
  // Message write strobe
  output logic            msg_wr,
  output logic [7:0]      msg_num
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins at time zero
  initial
  begin
    word0_b4 = 1'h0;
    word2_lo = 8'h00;
    msg_wr   = 1'h0;
    msg_num  = 8'h00;
  end

  // Number settles before the trigger bit, so a slow sync never sees a stale number
  task automatic word_event(input logic [7:0] n);
    @(posedge clk);
    word2_lo <= n;
    repeat (4) @(posedge clk);
    word0_b4 <= 1'h1;
    repeat (6) @(posedge clk);
    word0_b4 <= 1'h0;
  endtask : word_event

  // One-cycle write; the number is scrambled once the strobe is gone
  task automatic msg_event(input logic [7:0] n);
    @(posedge clk);
    msg_wr  <= 1'h1;
    msg_num <= n;
    @(posedge clk);
    msg_wr  <= 1'h0;
    msg_num <= ~n;
  endtask : msg_event
endmodule : edc_host_model

// ===== tb/tb_top.sv
// Testbench top: register tasks, dispatch waits and directed scenarios.
// Assumes edc_ctrl runs with a 10-cycle tick and a 20 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import edc_pkg::*;

  // Stimulus and observed signals
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic        rx_valid_p1 = 1'h0;
  logic [7:0]  rx_byte_p1 = 8'h00;
  logic        rx_valid_p2 = 1'h0;
  logic [7:0]  rx_byte_p2 = 8'h00;
  logic [7:0]  rtc_hour = 8'h00;
  logic [7:0]  rtc_min = 8'h00;
  logic [7:0]  rtc_sec = 8'h00;
  logic [9:0]  key_in = 10'h000;
  logic        fault_event = 1'h0;
  logic        op_busy = 1'h0;
  logic        handler_done = 1'h0;
  logic        word0_b4, msg_wr, handler_branch, fault_branch, busy_flag;
  logic [7:0]  word2_lo, msg_num;
  logic [6:0]  handler_vector;
  logic [31:0] rd_q;
  int          n_mismatch = 0;
  int          checked = 0;

  // 50 ns clock
  always #25 clk = ~clk;

  // Every input comes from a bench signal, so no rule hides behind a tie-off
  edc_ctrl #(.TICK_CYCLES(10)) u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_valid_p1(rx_valid_p1), .rx_byte_p1(rx_byte_p1), .rx_valid_p2(rx_valid_p2),
    .rx_byte_p2(rx_byte_p2), .key_in(key_in), .allocated_io_word0_b4(word0_b4),
    .allocated_io_word2_lo(word2_lo), .host_message_write(msg_wr),
    .host_message_num(msg_num), .rtc_hour(rtc_hour), .rtc_min(rtc_min), .rtc_sec(rtc_sec),
    .fault_event(fault_event), .op_busy(op_busy), .handler_done(handler_done),
    .handler_branch(handler_branch), .handler_vector(handler_vector),
    .fault_branch(fault_branch), .busy_flag(busy_flag));

  // Far-side host
  edc_host_model u_host (.clk(clk), .word0_b4(word0_b4), .word2_lo(word2_lo),
    .msg_wr(msg_wr), .msg_num(msg_num));

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Four-state compare of one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask : wr

  // Read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'h0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd

  // Bounded wait for a dispatch; f selects the fault branch
  task automatic wait_br(input logic f, input logic [6:0] v);
    int i;
    i = 0;
    @(negedge clk);
    while ((f ? fault_branch : handler_branch) !== 1'h1 && i < 60)
    begin
      @(negedge clk);
      i++;
    end
    if (f)
      chk({31'h0, fault_branch}, 32'h0000_0001);
    else
      chk({23'h0, busy_flag, handler_branch, handler_vector}, {23'h0, 2'h3, v});
  endtask : wait_br

  // One byte into the port 2 receive buffer
  task automatic rx2(input logic [7:0] b);
    @(posedge clk);
    rx_valid_p2 <= 1'h1;
    rx_byte_p2  <= b;
    @(posedge clk);
    rx_valid_p2 <= 1'h0;
  endtask : rx2

  // No ordinary dispatch for n cycles
  task automatic none(input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      @(negedge clk);
      c += (handler_branch === 1'h1) ? 1 : 0;
    end
    chk(c, 0);
  endtask : none

  // Handler return pulse
  task automatic done;
    @(posedge clk);
    handler_done <= 1'h1;
    @(posedge clk);
    handler_done <= 1'h0;
    @(negedge clk);
    chk({31'h0, busy_flag}, 32'h0000_0000);
  endtask : done

  // Watchdog well beyond the expected run length
  initial
  begin
    #(50 * 6000);
    n_mismatch++;
    wrap_up();
  end

  // Directed scenarios
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    rd(REG_GATE, 32'h0000_0000);
    rd(REG_TOD, 32'h0700_0000);
    rd(8'hFC, 32'h0000_0000);
    wr(REG_GATE, 32'h0000_0105);
    key_in[3] <= 1'h1;
    wait_br(1'h0, 7'h05);
    done();
    wr(REG_GATE, 32'h0000_0202);
    repeat (2)
    begin
      @(posedge clk);
      key_in[0] <= 1'h1;
      repeat (6) @(posedge clk);
      key_in[0] <= 1'h0;
      repeat (6) @(posedge clk);
    end
    none(5);
    rd(REG_GATE, 32'h0000_0602);
    wr(REG_GATE, 32'h0000_0102);
    wait_br(1'h0, 7'h02);
    done();
    none(20);
    wr(REG_GATE, 32'h0000_010B);
    wr(REG_GATE, 32'h0000_010C);
    op_busy <= 1'h1;
    key_in[9] <= 1'h1;
    u_host.word_event(8'h01);
    none(5);
    @(posedge clk);
    op_busy <= 1'h0;
    wait_br(1'h0, 7'h0B);
    done();
    wait_br(1'h0, 7'h0C);
    done();
    wr(REG_GATE, 32'h0000_0110);
    u_host.msg_event(8'h05);
    wait_br(1'h0, 7'h10);
    u_host.msg_event(8'h05);
    rd(REG_STATUS, 32'h0000_1005);
    done();
    none(10);
    wr(REG_STATUS, 32'h0000_0004);
    rd(REG_STATUS, 32'h0000_1000);
    wr(REG_PORT1, 32'h0000_4100);
    wr(REG_GATE, 32'h0000_0100);
    @(posedge clk);
    rx_valid_p1 <= 1'h1;
    rx_byte_p1  <= 8'h30;
    @(posedge clk);
    rx_byte_p1  <= 8'h41;
    @(posedge clk);
    rx_valid_p1 <= 1'h0;
    wait_br(1'h0, 7'h00);
    @(posedge clk);
    fault_event <= 1'h1;
    @(posedge clk);
    fault_event <= 1'h0;
    wait_br(1'h1, 7'h00);
    done();
    wr(REG_PORT2, 32'h0300_0001);
    wr(REG_GATE, 32'h0000_0101);
    rx2(8'h11);
    rx2(8'h12);
    none(3);
    rx2(8'h13);
    wait_br(1'h0, 7'h01);
    done();
    wr(REG_PORT2, 32'h0002_0302);
    rx2(8'h03);
    rx2(8'h02);
    none(3);
    rx2(8'h03);
    wait_br(1'h0, 7'h01);
    done();
    wr(REG_PORT2, 32'h0202_0003);
    rx2(8'h02);
    rx2(8'h61);
    none(3);
    rx2(8'h62);
    wait_br(1'h0, 7'h01);
    done();
    wr(REG_GATE, 32'h0000_0171);
    wr(REG_TOD, 32'h0003_0205);
    rtc_hour <= 8'h03;
    rtc_min  <= 8'h02;
    none(3);
    @(posedge clk);
    rtc_sec  <= 8'h05;
    wait_br(1'h0, 7'h71);
    done();
    wr(REG_GATE, 32'h0000_016F);
    wr(REG_ALARM, 32'h8000_0002);
    wait_br(1'h0, 7'h6F);
    done();
    none(60);
    wr(REG_GATE, 32'h0000_0170);
    wr(REG_TIMER, 32'h8000_0001);
    repeat (2)
    begin
      wait_br(1'h0, 7'h70);
      done();
    end
    wr(REG_GATE, 32'h0000_0070);
    none(40);
    wrap_up();
  end
endmodule : tb_top
